// File: inc/cmsd_pkg.sv
// Package for the CPU memory-space decoder: address constants, request carriers.
// Assumes a single 50 MHz clock domain shared with the CPU core.
package cmsd_pkg;

  // ****************************************************************
  // Address map constants
  // ****************************************************************
  localparam int          CMSD_CODE_BYTES   = 16384;       // Program store size
  localparam int          CMSD_CODE_AW      = 14;          // Program address bits used
  localparam logic [15:0] CMSD_RESET_PC     = 16'h0000;    // Fetch start after reset
  localparam logic [15:0] CMSD_VEC_BASE     = 16'h0003;    // First interrupt vector
  localparam int          CMSD_VEC_SHIFT    = 3;           // Vectors 8 bytes apart
  localparam logic [7:0]  CMSD_LOWER_TOP    = 8'h7F;       // Top of lower RAM / bit area
  localparam logic [7:0]  CMSD_BANK_SPAN    = 8'h08;       // Bytes per working bank
  localparam logic [7:0]  CMSD_BITRAM_BASE  = 8'h20;       // Bit-addressable RAM base
  localparam logic [7:0]  CMSD_SFR_BIT_MASK = 8'h07;       // Low bits zero on bit SFRs
  localparam int          CMSD_EXPRAM_BYTES = 576;         // Expanded RAM size
  localparam logic [15:0] CMSD_EXPRAM_TOP   = 16'h023F;    // Last expanded RAM address
  localparam logic [7:0]  CMSD_UNDEF_DATA   = 8'h00;       // Value read from holes

  // ****************************************************************
  // Enumerations and carriers
  // ****************************************************************
  // Kind of data access issued by the CPU
  typedef enum logic [2:0] {
    CMSD_ACC_DIRECT   = 3'd0,  // Direct byte address
    CMSD_ACC_INDIRECT = 3'd1,  // Register-indirect byte address
    CMSD_ACC_WREG     = 3'd2,  // Working register Rn, address holds n
    CMSD_ACC_BIT      = 3'd3,  // Single-bit address
    CMSD_ACC_XPAGED   = 3'd4,  // External move, register-indirect form
    CMSD_ACC_XDPTR    = 3'd5   // External move, data-pointer form
  } cmsd_acc_e;

  // Data request from the CPU
  typedef struct packed {
    logic        valid;  // Request present this cycle
    logic        write;  // 1 write, 0 read
    cmsd_acc_e   kind;   // Addressing form
    logic [15:0] addr;   // Byte, bit, register or external address
    logic [7:0]  wdata;  // Write data (merged whole byte for bit writes)
  } cmsd_req_s;

  // Read answer back to the CPU
  typedef struct packed {
    logic       valid;  // Answer present this cycle
    logic [7:0] rdata;  // Read byte (bit in bit 0 for RAM bit reads; whole byte for special-register bit reads)
  } cmsd_rsp_s;

  // Special-register port towards the peripherals
  typedef struct packed {
    logic       rd;     // Read strobe
    logic       wr;     // Write strobe
    logic [6:0] addr;   // Offset from 80H
    logic       bit_op; // Single-bit access
    logic [2:0] bitsel; // Bit within byte
    logic [7:0] wdata;  // Write byte or bit
  } cmsd_sfr_s;

endpackage : cmsd_pkg

// File: rtl/cmsd_decoder.sv
// CPU memory-space decoder: program fetch, internal data, special registers, expanded RAM.
// Assumes the CPU core issues at most one data request per cycle on the system clock.
//
// Notes on behaviour
// - Program store is 16K read-only flash; no write path from instructions.
// - No off-chip fetch: no access strap input, no program strobe output.
// - After reset the fetch address starts at zero.
// - Interrupt n vectors to 0003H plus 8 times n.
// - Internal data addresses are 8 bits, spanning 256 bytes.
// - Direct addresses above 7FH go to the special registers.
// - Indirect addresses above 7FH go to separate upper RAM.
// - Lowest 32 bytes are four banks of eight working registers.
// - Bank select 00..11 maps registers to 00H, 08H, 10H, 18H.
// - Bytes 20H..2FH are bit-addressable as bit addresses 00H..7FH.
// - Lower RAM direct or indirect; upper RAM indirect only.
// - Special registers are reachable only by direct or bit addressing.
// - Only special registers ending 0H or 8H accept bit access.
// - Expanded RAM is 0000H..023FH, reached only by external moves.
// - Paged form reaches low 256 bytes; data-pointer form reaches all 576.
// - Unoccupied special registers may read arbitrary data; firmware avoids them.
`timescale 1ns/1ps
`default_nettype none
module cmsd_decoder
  import cmsd_pkg::*;
#(
  parameter int NUM_VEC = 16
) (
  input  wire logic              CORE_CLK_I,     // System clock, 50 MHz
  input  wire logic              RESETN_I,       // Synchronous reset, active low
  input  wire logic              FETCH_I,        // Advance fetch address
  input  wire logic              JUMP_I,         // Load fetch address
  input  wire logic [15:0]       JUMP_ADDR_I,    // Jump target
  input  wire logic              IRQ_I,          // Enter interrupt vector
  input  wire logic [3:0]        IRQ_NUM_I,      // Interrupt source number
  input  wire logic              BANK_SEL_HI_I,  // bank_select_high_bit of status word
  input  wire logic              BANK_SEL_LO_I,  // bank_select_low_bit of status word
  input  wire cmsd_pkg::cmsd_req_s REQ_I,        // Data request
  input  wire logic [7:0]        SFR_RDATA_I,    // Special register read data
  input  wire logic [7:0]        CODE_DATA_I,    // Flash read data
  output logic [15:0]            FETCH_ADDR_O,   // Program fetch address
  output logic [13:0]            CODE_ADDR_O,    // Flash address
  output cmsd_pkg::cmsd_rsp_s    RSP_O,          // Data answer
  output cmsd_pkg::cmsd_sfr_s    SFR_O,          // Special register port
  output logic [7:0]             CODE_RDATA_O    // Registered flash byte
);
  import cmsd_pkg::*;

  // ****************************************************************
  // Program fetch
  // ****************************************************************
  logic [15:0] pc_r, pc_nxt;

  // Interrupt wins over jump, jump over sequential fetch
  always_comb begin
    pc_nxt = pc_r;
    if (IRQ_I) begin
      pc_nxt = CMSD_VEC_BASE + ({12'h000, IRQ_NUM_I} << CMSD_VEC_SHIFT);
    end else if (JUMP_I) begin
      pc_nxt = JUMP_ADDR_I;
    end else if (FETCH_I) begin
      pc_nxt = pc_r + 16'h0001;
    end
  end

  // Only the fetch port reads the flash; no write strobe exists toward it
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESETN_I) begin
      pc_r         <= CMSD_RESET_PC;
      CODE_RDATA_O <= 8'h00;
    end else begin
      pc_r         <= pc_nxt;
      CODE_RDATA_O <= CODE_DATA_I;
    end
  end

  assign FETCH_ADDR_O = pc_r;
  // Upper fetch bits are dropped: the store holds only 16K, no external bus
  assign CODE_ADDR_O  = pc_r[CMSD_CODE_AW-1:0];

  // ****************************************************************
  // Data-space decode
  // ****************************************************************
  typedef enum logic [4:0] {
    TGT_NONE  = 5'b00001,
    TGT_LOW   = 5'b00010,
    TGT_HIGH  = 5'b00100,
    TGT_SFR   = 5'b01000,
    TGT_EXPRAM = 5'b10000
  } cmsd_tgt_e;

  cmsd_tgt_e   tgt;
  logic [7:0]  iaddr;     // Internal byte address, always 8 bits
  logic [9:0]  xaddr;
  logic        is_bit;
  logic [2:0]  bsel;
  logic [7:0]  bank_base;

  // Bank base from the two select bits
  assign bank_base = {3'b000, BANK_SEL_HI_I, BANK_SEL_LO_I, 3'b000};

  // Route each request to at most one store; data-pointer moves beyond the top reach none
  always_comb begin
    tgt    = TGT_NONE;
    iaddr  = REQ_I.addr[7:0];
    xaddr  = REQ_I.addr[9:0];
    is_bit = 1'b0;
    bsel   = REQ_I.addr[2:0];
    if (REQ_I.valid) begin
      unique case (REQ_I.kind)
        CMSD_ACC_DIRECT: begin
          tgt = (iaddr > CMSD_LOWER_TOP) ? TGT_SFR : TGT_LOW;
        end
        CMSD_ACC_INDIRECT: begin
          tgt = (iaddr > CMSD_LOWER_TOP) ? TGT_HIGH : TGT_LOW;
        end
        CMSD_ACC_WREG: begin
          iaddr = bank_base | {5'b00000, REQ_I.addr[2:0]};
          tgt   = TGT_LOW;
        end
        CMSD_ACC_BIT: begin
          is_bit = 1'b1;
          if (REQ_I.addr[7:0] > CMSD_LOWER_TOP) begin
            // Bit region of special registers: only xxx0H/xxx8H bytes
            iaddr = REQ_I.addr[7:0] & ~CMSD_SFR_BIT_MASK;
            tgt   = TGT_SFR;
          end else begin
            iaddr = CMSD_BITRAM_BASE + {4'h0, REQ_I.addr[6:3]};
            tgt   = TGT_LOW;
          end
        end
        CMSD_ACC_XPAGED: begin
          xaddr = {2'b00, REQ_I.addr[7:0]};
          tgt   = TGT_EXPRAM;
        end
        CMSD_ACC_XDPTR: begin
          // Beyond the top no store answers; read gets a fixed value
          tgt = (REQ_I.addr <= CMSD_EXPRAM_TOP) ? TGT_EXPRAM : TGT_NONE;
        end
        default: begin
          tgt = TGT_NONE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Stores
  // ****************************************************************
  // Bit writes are read-modify-write; the CPU issues them as two cycles,
  // read first then write with the merged byte, so only byte writes land here.
  logic [7:0] low_q, high_q, expram_q, merged;
  logic       we_low, we_high, we_expram;

  assign we_low    = REQ_I.write && (tgt == TGT_LOW);
  assign we_high   = REQ_I.write && (tgt == TGT_HIGH);
  assign we_expram = REQ_I.write && (tgt == TGT_EXPRAM); // Only external moves reach it

  assign merged  = REQ_I.wdata;

  cmsd_ram #(.DEPTH(128), .AW(7)) u_low (
    .clk_i   (CORE_CLK_I),
    .we_i    (we_low),
    .addr_i  (iaddr[6:0]),
    .wdata_i (merged),
    .rdata_o (low_q)
  );

  cmsd_ram #(.DEPTH(128), .AW(7)) u_high (
    .clk_i   (CORE_CLK_I),
    .we_i    (we_high),
    .addr_i  (iaddr[6:0]),
    .wdata_i (merged),
    .rdata_o (high_q)
  );

  cmsd_ram #(.DEPTH(CMSD_EXPRAM_BYTES), .AW(10)) u_expram (
    .clk_i   (CORE_CLK_I),
    .we_i    (we_expram),
    .addr_i  (xaddr),
    .wdata_i (merged),
    .rdata_o (expram_q)
  );

  // ****************************************************************
  // Special register port and answer
  // ****************************************************************
  cmsd_sfr_s sfr_r, sfr_nxt;
  cmsd_rsp_s rsp_r, rsp_nxt;
  cmsd_tgt_e tgt_r;
  logic      bit_r;
  logic [2:0] bsel_r;

  // Strobe the peripherals; unoccupied offsets are theirs to ignore
  always_comb begin
    sfr_nxt        = '0;
    sfr_nxt.rd     = (tgt == TGT_SFR) && !REQ_I.write;
    sfr_nxt.wr     = (tgt == TGT_SFR) && REQ_I.write;
    sfr_nxt.addr   = iaddr[6:0];
    sfr_nxt.bit_op = is_bit;
    sfr_nxt.bitsel = bsel;
    sfr_nxt.wdata  = REQ_I.wdata;
  end

  // Read answer two cycles after the request, from whichever store was hit
  always_comb begin
    logic [7:0] b;
    b = CMSD_UNDEF_DATA;
    unique case (tgt_r)
      TGT_LOW:  b = low_q;
      TGT_HIGH: b = high_q;
      TGT_SFR:  b = SFR_RDATA_I;
      TGT_EXPRAM: b = expram_q;
      TGT_NONE: b = CMSD_UNDEF_DATA;
    endcase
    rsp_nxt.valid = rsp_r.valid;
    rsp_nxt.rdata = (bit_r && tgt_r != TGT_SFR) ? {7'h00, b[bsel_r]} : b;
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RESETN_I) begin
      sfr_r  <= '0;
      tgt_r  <= TGT_NONE;
      bit_r  <= 1'b0;
      bsel_r <= 3'd0;
      rsp_r  <= '0;
      RSP_O  <= '0;
    end else begin
      sfr_r       <= sfr_nxt;
      tgt_r       <= tgt;
      bit_r       <= is_bit;
      bsel_r      <= bsel;
      rsp_r.valid <= REQ_I.valid && !REQ_I.write;       // Every read completes
      rsp_r.rdata <= 8'h00;
      RSP_O       <= rsp_nxt;
    end
  end

  assign SFR_O = sfr_r;

endmodule : cmsd_decoder
`default_nettype wire

// File: rtl/cmsd_ram.sv
// Single-port synchronous byte RAM with one-cycle read latency.
// Assumes the caller keeps addresses inside DEPTH.
`timescale 1ns/1ps
`default_nettype none
module cmsd_ram #(
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  input  wire logic          clk_i,   // Clock
  input  wire logic          we_i,    // Write enable
  input  wire logic [AW-1:0] addr_i,  // Address
  input  wire logic [7:0]    wdata_i, // Write data
  output logic      [7:0]    rdata_o  // Read data, registered
);
  logic [7:0] mem [DEPTH];

  // Storage has no reset; contents are undefined until written
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
    rdata_o <= mem[addr_i];
  end
endmodule : cmsd_ram
`default_nettype wire

// File: tb/cmsd_decoder_assertions.sv
// Checker for the memory-space decoder, bound to its top module.
// Assumes the decoder timing: strobe seen one edge, answer two edges after a request edge.
`timescale 1ns/1ps
`default_nettype none
module cmsd_decoder_assertions (
  input wire logic              CORE_CLK_I,   // Clock
  input wire logic              RESETN_I,     // Reset, active low
  input wire logic              IRQ_I,        // Vector entry
  input wire logic [3:0]        IRQ_NUM_I,    // Source number
  input wire cmsd_pkg::cmsd_req_s REQ_I,      // Data request
  input wire logic [15:0]       FETCH_ADDR_O, // Fetch address
  input wire logic [13:0]       CODE_ADDR_O,  // Flash address
  input wire cmsd_pkg::cmsd_rsp_s RSP_O,      // Answer
  input wire cmsd_pkg::cmsd_sfr_s SFR_O       // Special register port
);
  import cmsd_pkg::*;
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RESETN_I);
  // ****************************************************************
  // Properties
  // ****************************************************************
  // Reset leaves fetch at zero and nothing answered
  property p_reset_pc;
    $rose(RESETN_I) |-> FETCH_ADDR_O == 16'h0000 && !RSP_O.valid;
  endproperty
  a_reset_pc: assert property (p_reset_pc) else $error("fetch not zero after reset");
  property p_vector;
    IRQ_I |=> FETCH_ADDR_O == 16'h0003 + {9'h000, $past(IRQ_NUM_I), 3'b000};
  endproperty
  a_vector: assert property (p_vector) else $error("wrong vector address");
  // Flash only ever sees the low 14 bits; there is no other program path
  property p_code_addr;
    CODE_ADDR_O == FETCH_ADDR_O[13:0];
  endproperty
  a_code_addr: assert property (p_code_addr) else $error("flash address mismatch");
  property p_sfr_direct;
    logic [7:0] a;
    logic       w;
    logic [7:0] d;
    (REQ_I.valid && REQ_I.kind == CMSD_ACC_DIRECT && REQ_I.addr[7],
      a = REQ_I.addr[7:0], w = REQ_I.write, d = REQ_I.wdata)
      |-> ##1 SFR_O.wr == w && SFR_O.rd == !w && SFR_O.addr == a[6:0] && !SFR_O.bit_op &&
      (!w || SFR_O.wdata == d);
  endproperty
  a_sfr_direct: assert property (p_sfr_direct) else $error("direct high not to sfr");
  property p_ram_only;
    REQ_I.valid && (REQ_I.kind == CMSD_ACC_INDIRECT || REQ_I.kind == CMSD_ACC_WREG ||
      (REQ_I.kind inside {CMSD_ACC_DIRECT, CMSD_ACC_BIT} && !REQ_I.addr[7]))
      |-> ##1 !SFR_O.rd && !SFR_O.wr;
  endproperty
  a_ram_only: assert property (p_ram_only) else $error("ram access hit sfr");
  property p_xmove_only;
    REQ_I.valid && REQ_I.kind inside {CMSD_ACC_XPAGED, CMSD_ACC_XDPTR}
      |-> ##1 !SFR_O.rd && !SFR_O.wr;
  endproperty
  a_xmove_only: assert property (p_xmove_only) else $error("external move hit sfr");
  property p_sfr_bit;
    logic [7:0] a;
    (REQ_I.valid && REQ_I.kind == CMSD_ACC_BIT && REQ_I.addr[7], a = REQ_I.addr[7:0])
      |-> ##1 SFR_O.bit_op && SFR_O.addr == {a[6:3], 3'b000} && SFR_O.bitsel == a[2:0];
  endproperty
  a_sfr_bit: assert property (p_sfr_bit) else $error("bad sfr bit decode");
  // Every read answers on time, writes never answer; nothing stalls
  property p_answer;
    logic w;
    (REQ_I.valid, w = REQ_I.write) |-> ##2 RSP_O.valid == !w;
  endproperty
  a_answer: assert property (p_answer) else $error("answer timing wrong");
  property p_hole;
    REQ_I.valid && !REQ_I.write && REQ_I.kind == CMSD_ACC_XDPTR && REQ_I.addr > 16'h023F
      |-> ##2 RSP_O.rdata == CMSD_UNDEF_DATA;
  endproperty
  a_hole: assert property (p_hole) else $error("hole read not undefined value");
  c_sfr_read: cover property (SFR_O.rd);
  c_irq: cover property (IRQ_I);
  c_hole: cover property (REQ_I.valid && REQ_I.addr > 16'h023F);
endmodule : cmsd_decoder_assertions
bind cmsd_decoder cmsd_decoder_assertions u_chk (
  .CORE_CLK_I(CORE_CLK_I), .RESETN_I(RESETN_I), .IRQ_I(IRQ_I), .IRQ_NUM_I(IRQ_NUM_I),
  .REQ_I(REQ_I), .FETCH_ADDR_O(FETCH_ADDR_O), .CODE_ADDR_O(CODE_ADDR_O), .RSP_O(RSP_O),
  .SFR_O(SFR_O));
`default_nettype wire

// File: tb/cmsd_decoder_tb_top.sv
// Testbench for the memory-space decoder with the peripheral model.
// Assumes the hand-over timing; bench drives inputs with NBA at rising edges.
`timescale 1ns/1ps
`default_nettype none
module cmsd_decoder_tb_top;
  import cmsd_pkg::*;
  logic       clk, rstn, fetch, jump, irq, bhi, blo;
  logic [15:0] jaddr, faddr;
  logic [3:0]  inum;
  logic [7:0]  sfr_rd, code_d, code_q;
  logic [13:0] caddr;
  cmsd_req_s   req;
  cmsd_rsp_s   rsp;
  cmsd_sfr_s   sfr;
  int          fails, n_compared;
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  cmsd_decoder u_dut (.CORE_CLK_I(clk), .RESETN_I(rstn), .FETCH_I(fetch), .JUMP_I(jump),
    .JUMP_ADDR_I(jaddr), .IRQ_I(irq), .IRQ_NUM_I(inum), .BANK_SEL_HI_I(bhi),
    .BANK_SEL_LO_I(blo), .REQ_I(req), .SFR_RDATA_I(sfr_rd), .CODE_DATA_I(code_d),
    .FETCH_ADDR_O(faddr), .CODE_ADDR_O(caddr), .RSP_O(rsp), .SFR_O(sfr), .CODE_RDATA_O(code_q));
  cmsd_periph_model u_model (.clk_i(clk), .sfr_i(sfr), .code_addr_i(caddr),
    .sfr_rdata_o(sfr_rd), .code_data_o(code_d));
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic print_verdict();
    if (fails == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One program-counter control pulse, then compare the new fetch address
  task automatic pc(input logic f, j, i, input logic [15:0] ja, e, input logic [3:0] n);
    @(posedge clk);
    fetch <= f;
    jump <= j;
    irq <= i;
    jaddr <= ja;
    inum <= n;
    @(posedge clk);
    fetch <= 1'b0;
    jump <= 1'b0;
    irq <= 1'b0;
    #1 chk("fetch addr", e, faddr);
  endtask : pc
  // One request; for reads d is the expected byte, waited for under a bound
  task automatic rq(input logic w, input cmsd_acc_e k, input logic [15:0] a, input logic [7:0] d);
    int t;
    @(posedge clk);
    req <= '{1'b1, w, k, a, d};
    @(posedge clk);
    req.valid <= 1'b0;
    t = 0;
    if (!w) begin
      #1;
      while (rsp.valid !== 1'b1 && t < 5) begin
        @(posedge clk);
        #1 t++;
      end
      if (rsp.valid !== 1'b1) begin
        fails++;
        print_verdict();
      end else begin
        chk("read data", {8'h00, d}, {8'h00, rsp.rdata});
      end
    end
  endtask : rq
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_fetch();
    #1 chk("reset addr", 16'h0000, faddr);
    pc(1'b1, 1'b0, 1'b0, 16'h0000, 16'h0001, 4'd0);
    pc(1'b1, 1'b1, 1'b1, 16'h1234, 16'h0013, 4'd2);
    for (int n = 0; n < 16; n++) begin
      pc(1'b0, 1'b0, 1'b1, 16'h0000, 16'h0003 + 16'(n * 8), n[3:0]);
    end
    pc(1'b0, 1'b1, 1'b0, 16'h4ABC, 16'h4ABC, 4'd0);
    @(posedge clk);
    #1 chk("code addr", 16'h0ABC, {2'b00, caddr});
    chk("code byte", 16'h0019, {8'h00, code_q});
    rstn <= 1'b0;
    @(posedge clk);
    rstn <= 1'b1;
    #1 chk("second reset", 16'h0000, faddr);
  endtask : t_fetch
  task automatic t_banks();
    for (int b = 0; b < 4; b++) begin
      @(posedge clk);
      bhi <= b[1];
      blo <= b[0];
      rq(1'b1, CMSD_ACC_WREG, 16'h0005, 8'hB0 | b[7:0]);
      rq(1'b0, CMSD_ACC_DIRECT, 16'(b * 8 + 5), 8'hB0 | b[7:0]);
    end
  endtask : t_banks
  task automatic t_upper();
    rq(1'b1, CMSD_ACC_INDIRECT, 16'h0090, 8'hA5);
    rq(1'b1, CMSD_ACC_DIRECT, 16'h0090, 8'h11);
    rq(1'b0, CMSD_ACC_DIRECT, 16'h0090, 8'hAC);
    rq(1'b0, CMSD_ACC_INDIRECT, 16'h0090, 8'hA5);
    rq(1'b1, CMSD_ACC_DIRECT, 16'h007F, 8'h5E);
    rq(1'b0, CMSD_ACC_INDIRECT, 16'h007F, 8'h5E);
    rq(1'b1, CMSD_ACC_INDIRECT, 16'h00FF, 8'hC7);
    rq(1'b0, CMSD_ACC_INDIRECT, 16'h00FF, 8'hC7);
  endtask : t_upper
  task automatic t_bits();
    rq(1'b1, CMSD_ACC_DIRECT, 16'h0021, 8'h08);
    rq(1'b0, CMSD_ACC_BIT, 16'h000B, 8'h01);
    rq(1'b0, CMSD_ACC_BIT, 16'h000C, 8'h00);
    rq(1'b1, CMSD_ACC_BIT, 16'h007F, 8'h80);
    rq(1'b0, CMSD_ACC_DIRECT, 16'h002F, 8'h80);
    rq(1'b0, CMSD_ACC_BIT, 16'h0093, 8'hAC);
  endtask : t_bits
  task automatic t_expram();
    rq(1'b1, CMSD_ACC_XDPTR, 16'h0000, 8'h21);
    rq(1'b1, CMSD_ACC_XDPTR, 16'h023F, 8'h3C);
    rq(1'b1, CMSD_ACC_XPAGED, 16'h01FF, 8'h77);
    rq(1'b1, CMSD_ACC_XDPTR, 16'h0240, 8'h99);
    rq(1'b0, CMSD_ACC_XDPTR, 16'h023F, 8'h3C);
    rq(1'b0, CMSD_ACC_XDPTR, 16'h00FF, 8'h77);
    rq(1'b0, CMSD_ACC_XPAGED, 16'h00FF, 8'h77);
    rq(1'b0, CMSD_ACC_XDPTR, 16'h0240, 8'h00);
    rq(1'b0, CMSD_ACC_XDPTR, 16'h0000, 8'h21);
    rq(1'b0, CMSD_ACC_INDIRECT, 16'h00FF, 8'hC7);
  endtask : t_expram
  // Hang guard: a run this long counts as a failure
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    print_verdict();
  end
  initial begin
    {rstn, fetch, jump, irq, bhi, blo, jaddr, inum} = '0;
    req = '0;
    fails = 0;
    n_compared = 0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    t_fetch();
    t_banks();
    t_upper();
    t_bits();
    t_expram();
    print_verdict();
  end
endmodule : cmsd_decoder_tb_top
`default_nettype wire

// File: tb/cmsd_periph_model.sv
// Far-side model: peripheral read data and flash contents.
// Assumes one clock; read data stands only in the cycle of the read strobe.
`timescale 1ns/1ps
`default_nettype none
module cmsd_periph_model (
  input  wire logic               clk_i,       // Clock
  input  wire cmsd_pkg::cmsd_sfr_s sfr_i,      // Strobes from decoder
  input  wire logic [13:0]        code_addr_i, // Flash address
  output logic      [7:0]         sfr_rdata_o, // Peripheral read data
  output logic      [7:0]         code_data_o  // Flash byte
);
  import cmsd_pkg::*;
  logic [7:0] idle_r;
  initial idle_r = 8'h00;
  // Idle value toggles so a late or early capture shows up
  always @(posedge clk_i) begin
    idle_r <= ~idle_r;
  end
  // The decoder captures read data at the edge that ends its strobe cycle
  assign sfr_rdata_o = sfr_i.rd ? ({1'b1, sfr_i.addr} ^ 8'h3C) : idle_r;
  // Flash byte follows its address so a wrong address is visible
  assign code_data_o = code_addr_i[7:0] ^ 8'hA5;
endmodule : cmsd_periph_model
`default_nettype wire
